// ---- gic_pkg.sv ----
// constants and types of the grouped interrupt controller
//----------------------------------------------------------------
// What this block does
//----------------------------------------------------------------
// What this block does
// RQ1: group 0 register: cmp zero flag b5, autoshutdown flag b4, enables b1,b0; reset 0.
// RQ2: bits 7:6 and 3:2 of every group register read as zero.
// RQ3: group 1 register: timer three flag b5, retrigger flag b4, enables b1,b0.
// RQ4: group 2 register: timer one flag b5, timer zero flag b4, enables b1,b0.
// RQ5: group 3 register: timer two flag b5, pulse timer flag b4, enables b1,b0.
// RQ6: source flags in group registers never clear on service; software clears them.
// RQ7: primary control: twowire b3, group one b2, group zero b1, group three b0.
// RQ8: events always set flags; vector taken only when the enable is one.
// RQ9: global enable low blocks every interrupt.
// RQ10: taking an interrupt pushes next address and loads the vector.
// RQ11: return from interrupt pops the saved address and resumes.
// RQ12: service clears global enable; new requests still set flags.
// RQ13: full stack blocks acknowledge until the stack pointer drops.
// RQ14: any flag newly set wakes the device from sleep or idle.
// RQ15: cmp zero change sets flag; group vector needs global, source, group enables.
// RQ16: cmp one to five transitions set own flags; service clears flag and global.
// RQ17: falling edge of cmp edge event sets its flag; service clears it.
// RQ18: all four timer overflows go through group interrupts.
// RQ19: enabled member flag sets group flag; group service clears group flag.
// RQ20: simultaneous requests served in fixed priority, one vector per source.
package gic_pkg;
  // ----------------------------------------------------------------
  // register word addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] GIC_ADDR_PRIM0 = 12'h000;
  localparam logic [11:0] GIC_ADDR_PRIM1 = 12'h004;
  localparam logic [11:0] GIC_ADDR_PRIM2 = 12'h008;
  localparam logic [11:0] GIC_ADDR_PRIM3 = 12'h00c;
  localparam logic [11:0] GIC_ADDR_GRP0 = 12'h010;
  localparam logic [11:0] GIC_ADDR_GRP1 = 12'h014;
  localparam logic [11:0] GIC_ADDR_GRP2 = 12'h018;
  localparam logic [11:0] GIC_ADDR_GRP3 = 12'h01c;
  localparam logic [11:0] GIC_ADDR_STAT = 12'h020;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GIC_GRP_FLAG_HI = 5;
  localparam int GIC_GRP_FLAG_LO = 4;
  localparam int GIC_GRP_EN_HI = 1;
  localparam int GIC_GRP_EN_LO = 0;
  localparam logic [7:0] GIC_GRP_MASK = 8'h33;
  localparam logic [7:0] GIC_PRIM0_MASK = 8'h7f;
  localparam logic [7:0] GIC_RESET8 = 8'h00;
  localparam logic [31:0] GIC_ZERO32 = 32'h0000_0000;
  // primary control 0: edge flag b6, cmp1 flag b5, cmp4 flag b4, edge en b3,
  // cmp1 en b2, cmp4 en b1, global b0
  localparam int GIC_P0_EDGE_F = 6;
  localparam int GIC_P0_C1_F = 5;
  localparam int GIC_P0_C4_F = 4;
  localparam int GIC_P0_EDGE_E = 3;
  localparam int GIC_P0_C1_E = 2;
  localparam int GIC_P0_C4_E = 1;
  localparam int GIC_P0_GLOBAL = 0;
  // primary control 1: cmp3 f b7, cmp2 f b6, cmp3 e b3, cmp2 e b2
  localparam int GIC_P1_C3_F = 7;
  localparam int GIC_P1_C2_F = 6;
  localparam int GIC_P1_C3_E = 3;
  localparam int GIC_P1_C2_E = 2;
  // primary control 2: cmp5 f b6, group2 f b5, cmp5 e b2, group2 e b1
  localparam int GIC_P2_C5_F = 6;
  localparam int GIC_P2_G2_F = 5;
  localparam int GIC_P2_C5_E = 2;
  localparam int GIC_P2_G2_E = 1;
  // primary control 3: twowire f b7, g1 f b6, g0 f b5, g3 f b4, enables b3..b0
  localparam int GIC_P3_TW_F = 7;
  localparam int GIC_P3_G1_F = 6;
  localparam int GIC_P3_G0_F = 5;
  localparam int GIC_P3_G3_F = 4;
  localparam int GIC_P3_TW_E = 3;
  localparam int GIC_P3_G1_E = 2;
  localparam int GIC_P3_G0_E = 1;
  localparam int GIC_P3_G3_E = 0;
  localparam int GIC_NSRC = 11;
  // ----------------------------------------------------------------
  // vectors, priority order index 0 highest
  // ----------------------------------------------------------------
  localparam logic [11:0] GIC_VEC_BASE = 12'h004;
  localparam logic [11:0] GIC_VEC_STEP = 12'h004;
  typedef enum logic [1:0] {
    GIC_IDLE = 2'b00,
    GIC_ACK = 2'b01,
    GIC_WAIT = 2'b11
  } gic_state_t;
  typedef struct packed {
    gic_state_t state;
    logic [7:0] prim0;
    logic [7:0] prim1;
    logic [7:0] prim2;
    logic [7:0] prim3;
    logic [7:0] grp0;
    logic [7:0] grp1;
    logic [7:0] grp2;
    logic [7:0] grp3;
    logic edge_prev;
    logic [5:0] cmp_prev;
    logic irq_take;
    logic [11:0] irq_vector;
    logic [11:0] push_addr;
    logic pc_pop;
    logic wake;
    logic [10:0] last_flags;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } gic_regs_t;
endpackage : gic_pkg

// ---- gic_top.sv ----
// grouped interrupt controller with apb register access
`timescale 1ns/100ps
module gic_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [5:0] cmp_out,
  input wire logic cmp_edge_event_signal,
  input wire logic pulse_autoshutdown_evt,
  input wire logic pulse_retrigger_evt,
  input wire logic pulse_timer_evt,
  input wire logic [3:0] timer_ovf_evt,
  input wire logic twowire_evt,
  input wire logic [11:0] next_pc,
  input wire logic stack_full,
  input wire logic irq_accept,
  input wire logic return_from_interrupt,
  output logic irq_take,
  output logic [11:0] irq_vector,
  output logic [11:0] push_addr,
  output logic pc_pop,
  output logic wake
);
  gic_pkg::gic_regs_t r;
  gic_pkg::gic_regs_t next_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] gic_grp_read(input logic [7:0] g);
    return g & gic_pkg::GIC_GRP_MASK; // RQ2
  endfunction : gic_grp_read

  function automatic logic [7:0] gic_grp_write(input logic [7:0] g, input logic [7:0] d,
                                               input logic [1:0] ev);
    logic [7:0] v;
    v = d & gic_pkg::GIC_GRP_MASK;
    v[gic_pkg::GIC_GRP_FLAG_HI] = v[gic_pkg::GIC_GRP_FLAG_HI] | ev[1];
    v[gic_pkg::GIC_GRP_FLAG_LO] = v[gic_pkg::GIC_GRP_FLAG_LO] | ev[0];
    return v;
  endfunction : gic_grp_write

  function automatic logic gic_grp_req(input logic [7:0] g);
    return (g[gic_pkg::GIC_GRP_FLAG_HI] & g[gic_pkg::GIC_GRP_EN_HI])
         | (g[gic_pkg::GIC_GRP_FLAG_LO] & g[gic_pkg::GIC_GRP_EN_LO]); // RQ19
  endfunction : gic_grp_req

  function automatic logic gic_grp_rise(input logic [7:0] cur, input logic [7:0] prev);
    return (cur[gic_pkg::GIC_GRP_FLAG_HI] & ~prev[gic_pkg::GIC_GRP_FLAG_HI])
         | (cur[gic_pkg::GIC_GRP_FLAG_LO] & ~prev[gic_pkg::GIC_GRP_FLAG_LO]); // RQ14
  endfunction : gic_grp_rise

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [31:0] rd;
  logic wr;
  logic rdv;
  logic [3:0] grp_set;
  logic [10:0] pend;
  logic [10:0] flags_now;
  logic [3:0] pick;
  logic found;
  logic [5:0] cmp_chg;
  logic edge_fall;

  always_comb begin
    next_r = r;
    wr = psel & penable & pwrite;
    rdv = 1'b1;
    rd = gic_pkg::GIC_ZERO32;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.irq_take = 1'b0;
    next_r.pc_pop = 1'b0;
    cmp_chg = cmp_out ^ r.cmp_prev;
    edge_fall = r.edge_prev & ~cmp_edge_event_signal;
    next_r.cmp_prev = cmp_out;
    next_r.edge_prev = cmp_edge_event_signal;
    // register write, events then win over clears
    if (wr && r.pready) begin
      if (paddr == gic_pkg::GIC_ADDR_PRIM0) begin
        next_r.prim0 = pwdata[7:0] & gic_pkg::GIC_PRIM0_MASK;
      end else if (paddr == gic_pkg::GIC_ADDR_PRIM1) begin
        next_r.prim1 = pwdata[7:0];
      end else if (paddr == gic_pkg::GIC_ADDR_PRIM2) begin
        next_r.prim2 = pwdata[7:0];
      end else if (paddr == gic_pkg::GIC_ADDR_PRIM3) begin
        next_r.prim3 = pwdata[7:0];
      end else if (paddr == gic_pkg::GIC_ADDR_GRP0) begin
        next_r.grp0 = gic_grp_write(r.grp0, pwdata[7:0], 2'b00); // RQ1
      end else if (paddr == gic_pkg::GIC_ADDR_GRP1) begin
        next_r.grp1 = gic_grp_write(r.grp1, pwdata[7:0], 2'b00); // RQ3
      end else if (paddr == gic_pkg::GIC_ADDR_GRP2) begin
        next_r.grp2 = gic_grp_write(r.grp2, pwdata[7:0], 2'b00); // RQ4
      end else if (paddr == gic_pkg::GIC_ADDR_GRP3) begin
        next_r.grp3 = gic_grp_write(r.grp3, pwdata[7:0], 2'b00); // RQ5
      end
    end
    // source events set flags regardless of enables
    next_r.grp0[gic_pkg::GIC_GRP_FLAG_HI] = next_r.grp0[gic_pkg::GIC_GRP_FLAG_HI] | cmp_chg[0]; // RQ15
    next_r.grp0[gic_pkg::GIC_GRP_FLAG_LO] = next_r.grp0[gic_pkg::GIC_GRP_FLAG_LO]
                                          | pulse_autoshutdown_evt; // RQ8
    next_r.grp1[gic_pkg::GIC_GRP_FLAG_HI] = next_r.grp1[gic_pkg::GIC_GRP_FLAG_HI] | timer_ovf_evt[3]; // RQ18
    next_r.grp1[gic_pkg::GIC_GRP_FLAG_LO] = next_r.grp1[gic_pkg::GIC_GRP_FLAG_LO] | pulse_retrigger_evt;
    next_r.grp2[gic_pkg::GIC_GRP_FLAG_HI] = next_r.grp2[gic_pkg::GIC_GRP_FLAG_HI] | timer_ovf_evt[1];
    next_r.grp2[gic_pkg::GIC_GRP_FLAG_LO] = next_r.grp2[gic_pkg::GIC_GRP_FLAG_LO] | timer_ovf_evt[0];
    next_r.grp3[gic_pkg::GIC_GRP_FLAG_HI] = next_r.grp3[gic_pkg::GIC_GRP_FLAG_HI] | timer_ovf_evt[2];
    next_r.grp3[gic_pkg::GIC_GRP_FLAG_LO] = next_r.grp3[gic_pkg::GIC_GRP_FLAG_LO] | pulse_timer_evt;
    next_r.prim0[gic_pkg::GIC_P0_EDGE_F] = next_r.prim0[gic_pkg::GIC_P0_EDGE_F] | edge_fall; // RQ17
    next_r.prim0[gic_pkg::GIC_P0_C1_F] = next_r.prim0[gic_pkg::GIC_P0_C1_F] | cmp_chg[1]; // RQ16
    next_r.prim1[gic_pkg::GIC_P1_C2_F] = next_r.prim1[gic_pkg::GIC_P1_C2_F] | cmp_chg[2];
    next_r.prim1[gic_pkg::GIC_P1_C3_F] = next_r.prim1[gic_pkg::GIC_P1_C3_F] | cmp_chg[3];
    next_r.prim0[gic_pkg::GIC_P0_C4_F] = next_r.prim0[gic_pkg::GIC_P0_C4_F] | cmp_chg[4];
    next_r.prim2[gic_pkg::GIC_P2_C5_F] = next_r.prim2[gic_pkg::GIC_P2_C5_F] | cmp_chg[5];
    next_r.prim3[gic_pkg::GIC_P3_TW_F] = next_r.prim3[gic_pkg::GIC_P3_TW_F] | twowire_evt;
    // group flags follow enabled members
    grp_set = {gic_grp_req(next_r.grp3) & ~gic_grp_req(r.grp3),
               gic_grp_req(next_r.grp2) & ~gic_grp_req(r.grp2),
               gic_grp_req(next_r.grp1) & ~gic_grp_req(r.grp1),
               gic_grp_req(next_r.grp0) & ~gic_grp_req(r.grp0)}; // RQ19
    next_r.prim3[gic_pkg::GIC_P3_G0_F] = next_r.prim3[gic_pkg::GIC_P3_G0_F] | grp_set[0];
    next_r.prim3[gic_pkg::GIC_P3_G1_F] = next_r.prim3[gic_pkg::GIC_P3_G1_F] | grp_set[1];
    next_r.prim2[gic_pkg::GIC_P2_G2_F] = next_r.prim2[gic_pkg::GIC_P2_G2_F] | grp_set[2];
    next_r.prim3[gic_pkg::GIC_P3_G3_F] = next_r.prim3[gic_pkg::GIC_P3_G3_F] | grp_set[3];
    // pending vectors in priority order
    pend[0] = r.prim0[gic_pkg::GIC_P0_EDGE_F] & r.prim0[gic_pkg::GIC_P0_EDGE_E];
    pend[1] = r.prim0[gic_pkg::GIC_P0_C1_F] & r.prim0[gic_pkg::GIC_P0_C1_E];
    pend[2] = r.prim0[gic_pkg::GIC_P0_C4_F] & r.prim0[gic_pkg::GIC_P0_C4_E];
    pend[3] = r.prim1[gic_pkg::GIC_P1_C2_F] & r.prim1[gic_pkg::GIC_P1_C2_E];
    pend[4] = r.prim1[gic_pkg::GIC_P1_C3_F] & r.prim1[gic_pkg::GIC_P1_C3_E];
    pend[5] = r.prim2[gic_pkg::GIC_P2_C5_F] & r.prim2[gic_pkg::GIC_P2_C5_E];
    pend[6] = r.prim3[gic_pkg::GIC_P3_G0_F] & r.prim3[gic_pkg::GIC_P3_G0_E]; // RQ7
    pend[7] = r.prim3[gic_pkg::GIC_P3_G1_F] & r.prim3[gic_pkg::GIC_P3_G1_E];
    pend[8] = r.prim2[gic_pkg::GIC_P2_G2_F] & r.prim2[gic_pkg::GIC_P2_G2_E];
    pend[9] = r.prim3[gic_pkg::GIC_P3_G3_F] & r.prim3[gic_pkg::GIC_P3_G3_E];
    pend[10] = r.prim3[gic_pkg::GIC_P3_TW_F] & r.prim3[gic_pkg::GIC_P3_TW_E];
    found = 1'b0;
    pick = 4'h0;
    for (int i = 0; i < gic_pkg::GIC_NSRC; i++) begin
      if (pend[i] && !found) begin // RQ20
        found = 1'b1;
        pick = 4'(i);
      end
    end
    // wake on any flag rising
    flags_now = {r.prim3[gic_pkg::GIC_P3_TW_F], r.prim3[gic_pkg::GIC_P3_G3_F],
                 r.prim2[gic_pkg::GIC_P2_G2_F], r.prim3[gic_pkg::GIC_P3_G1_F],
                 r.prim3[gic_pkg::GIC_P3_G0_F], r.prim2[gic_pkg::GIC_P2_C5_F],
                 r.prim1[gic_pkg::GIC_P1_C3_F], r.prim1[gic_pkg::GIC_P1_C2_F],
                 r.prim0[gic_pkg::GIC_P0_C4_F], r.prim0[gic_pkg::GIC_P0_C1_F],
                 r.prim0[gic_pkg::GIC_P0_EDGE_F]};
    next_r.last_flags = flags_now;
    next_r.wake = |(flags_now & ~r.last_flags)
                | gic_grp_rise(next_r.grp0, r.grp0) | gic_grp_rise(next_r.grp1, r.grp1)
                | gic_grp_rise(next_r.grp2, r.grp2) | gic_grp_rise(next_r.grp3, r.grp3); // RQ14
    // service sequencer
    case (r.state)
      gic_pkg::GIC_IDLE: begin
        if (r.prim0[gic_pkg::GIC_P0_GLOBAL] && found && !stack_full) begin // RQ9 RQ13
          next_r.state = gic_pkg::GIC_ACK;
          next_r.irq_take = 1'b1; // RQ10
          next_r.irq_vector = 12'(gic_pkg::GIC_VEC_BASE + gic_pkg::GIC_VEC_STEP * 12'(pick));
          next_r.push_addr = next_pc;
          next_r.prim0[gic_pkg::GIC_P0_GLOBAL] = 1'b0; // RQ12
          case (pick)
            4'h0: next_r.prim0[gic_pkg::GIC_P0_EDGE_F] = edge_fall; // RQ17
            4'h1: next_r.prim0[gic_pkg::GIC_P0_C1_F] = cmp_chg[1]; // RQ16
            4'h2: next_r.prim0[gic_pkg::GIC_P0_C4_F] = cmp_chg[4];
            4'h3: next_r.prim1[gic_pkg::GIC_P1_C2_F] = cmp_chg[2];
            4'h4: next_r.prim1[gic_pkg::GIC_P1_C3_F] = cmp_chg[3];
            4'h5: next_r.prim2[gic_pkg::GIC_P2_C5_F] = cmp_chg[5];
            4'h6: next_r.prim3[gic_pkg::GIC_P3_G0_F] = grp_set[0]; // RQ15 RQ6
            4'h7: next_r.prim3[gic_pkg::GIC_P3_G1_F] = grp_set[1];
            4'h8: next_r.prim2[gic_pkg::GIC_P2_G2_F] = grp_set[2];
            4'h9: next_r.prim3[gic_pkg::GIC_P3_G3_F] = grp_set[3];
            default: next_r.prim3[gic_pkg::GIC_P3_TW_F] = twowire_evt;
          endcase
        end
      end
      gic_pkg::GIC_ACK: begin
        next_r.irq_take = ~irq_accept;
        if (irq_accept) begin
          next_r.state = gic_pkg::GIC_WAIT;
        end
      end
      default: begin
        if (return_from_interrupt) begin // RQ11
          next_r.pc_pop = 1'b1;
          next_r.state = gic_pkg::GIC_IDLE;
        end
      end
    endcase
    // apb read and handshake
    if (paddr == gic_pkg::GIC_ADDR_PRIM0) begin
      rd = {24'h000000, r.prim0};
    end else if (paddr == gic_pkg::GIC_ADDR_PRIM1) begin
      rd = {24'h000000, r.prim1};
    end else if (paddr == gic_pkg::GIC_ADDR_PRIM2) begin
      rd = {24'h000000, r.prim2};
    end else if (paddr == gic_pkg::GIC_ADDR_PRIM3) begin
      rd = {24'h000000, r.prim3};
    end else if (paddr == gic_pkg::GIC_ADDR_GRP0) begin
      rd = {24'h000000, gic_grp_read(r.grp0)}; // RQ2
    end else if (paddr == gic_pkg::GIC_ADDR_GRP1) begin
      rd = {24'h000000, gic_grp_read(r.grp1)};
    end else if (paddr == gic_pkg::GIC_ADDR_GRP2) begin
      rd = {24'h000000, gic_grp_read(r.grp2)};
    end else if (paddr == gic_pkg::GIC_ADDR_GRP3) begin
      rd = {24'h000000, gic_grp_read(r.grp3)};
    end else if (paddr == gic_pkg::GIC_ADDR_STAT) begin
      rd = {30'h00000000, r.state};
    end else begin
      rdv = 1'b0;
    end
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = rd;
      if (!rdv) begin
        next_r.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign irq_take = r.irq_take;
  assign irq_vector = r.irq_vector;
  assign push_addr = r.push_addr;
  assign pc_pop = r.pc_pop;
  assign wake = r.wake;
endmodule : gic_top

// ---- gic_core_model.sv ----
// core side model: accepts a vector, runs a service routine, then returns
`timescale 1ns/100ps
module gic_core_model #(
  parameter logic [11:0] MAIN_PC = 12'h5a5,
  parameter int SVC = 30
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic irq_take,
  input wire logic slow,
  output logic irq_accept,
  output logic return_from_interrupt,
  output logic [11:0] next_pc
);
  logic [5:0] cnt;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 6'h00;
    end else if (irq_take || cnt != 6'h00) begin
      cnt <= (cnt == 6'(SVC)) ? 6'h00 : cnt + 6'h01;
    end
  end
  assign irq_accept = irq_take && (cnt >= (slow ? 6'h04 : 6'h01));
  assign return_from_interrupt = (cnt == 6'(SVC));
  assign next_pc = MAIN_PC;
endmodule : gic_core_model

// ---- gic_monitor.sv ----
// assertion checker on the controller ports
`timescale 1ns/100ps
module gic_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] next_pc,
  input wire logic stack_full,
  input wire logic irq_accept,
  input wire logic return_from_interrupt,
  input wire logic irq_take,
  input wire logic [11:0] irq_vector,
  input wire logic [11:0] push_addr,
  input wire logic pc_pop
);
  logic glob_sh;
  logic take_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      glob_sh <= 1'b0;
      take_q <= 1'b0;
    end else begin
      take_q <= irq_take;
      if (psel && penable && pready && pwrite && paddr == gic_pkg::GIC_ADDR_PRIM0) begin
        glob_sh <= pwdata[gic_pkg::GIC_P0_GLOBAL];
      end else if (irq_take && !take_q) begin
        glob_sh <= 1'b0;
      end
    end
  end
  sequence apb_access;
    psel && $rose(penable);
  endsequence
  sequence new_take;
    $rose(irq_take);
  endsequence
  ready_timing_a: assert property (apb_access |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  err_qual_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  vec_range_a: assert property (new_take |-> irq_vector[1:0] == 2'b00 &&
    irq_vector >= 12'h004 && irq_vector <= 12'h02c) else $error("vector out of range");
  push_pc_a: assert property (new_take |-> push_addr == $past(next_pc))
    else $error("saved address wrong");
  take_hold_a: assert property (irq_take && !irq_accept |=> irq_take && $stable(irq_vector))
    else $error("take request not held");
  accept_drop_a: assert property (irq_take && irq_accept |=> !irq_take)
    else $error("take not released after accept");
  stack_block_a: assert property (new_take |-> !$past(stack_full))
    else $error("take while stack full");
  global_gate_a: assert property (new_take |-> $past(glob_sh))
    else $error("take with global enable low");
  pop_after_ret_a: assert property (pc_pop |-> $past(return_from_interrupt) ##1 !pc_pop)
    else $error("pop not after return");
endmodule : gic_monitor

// ---- gic_top_tb.sv ----
// self-checking testbench of the grouped interrupt controller
`timescale 1ns/100ps
module gic_top_tb;
  logic sys_clk, resetn, psel, penable, pwrite, stack_full, slow, pready, pslverr, rd_e;
  logic [11:0] paddr, next_pc, irq_vector, push_addr;
  logic [31:0] pwdata, prdata, rd_d;
  logic [5:0] cmp_out;
  logic [3:0] timer_ovf_evt;
  logic cmp_edge_event_signal, pulse_autoshutdown_evt, pulse_retrigger_evt, pulse_timer_evt;
  logic twowire_evt, irq_accept, return_from_interrupt, irq_take, pc_pop, wake;
  int error_cnt, n_checks;
  gic_top gic_top_i (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cmp_out, .cmp_edge_event_signal, .pulse_autoshutdown_evt,
    .pulse_retrigger_evt, .pulse_timer_evt, .timer_ovf_evt, .twowire_evt, .next_pc, .stack_full,
    .irq_accept, .return_from_interrupt, .irq_take, .irq_vector, .push_addr, .pc_pop, .wake);
  gic_core_model gic_core_model_i (.sys_clk, .resetn, .irq_take, .slow, .irq_accept,
    .return_from_interrupt, .next_pc);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr
  task rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd_d, {24'h000000, exp});
  endtask : rdc
  task no_take(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      chk(32'(irq_take), 32'h0);
    end
  endtask : no_take
  task take(input logic [11:0] v);
    int i;
    i = 0;
    while (irq_take !== 1'b1 && i < 40) begin
      @(posedge sys_clk);
      i++;
    end
    chk(32'(irq_take), 32'h1);
    chk(32'(irq_vector), 32'(v));
    chk(32'(push_addr), 32'h5a5);
  endtask : take
  task pop();
    int i;
    i = 0;
    while (pc_pop !== 1'b1 && i < 60) begin
      @(posedge sys_clk);
      i++;
    end
    chk(32'(pc_pop), 32'h1);
  endtask : pop
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs();
    for (int i = 0; i < 4; i++) begin
      rdc(gic_pkg::GIC_ADDR_GRP0 + 12'(4 * i), 8'h00);
      wr(gic_pkg::GIC_ADDR_GRP0 + 12'(4 * i), 8'hff);
      rdc(gic_pkg::GIC_ADDR_GRP0 + 12'(4 * i), 8'h33);
      wr(gic_pkg::GIC_ADDR_GRP0 + 12'(4 * i), 8'h00);
    end
    wr(gic_pkg::GIC_ADDR_PRIM2, 8'h00);
    wr(gic_pkg::GIC_ADDR_PRIM3, 8'h00);
    apb(1'b0, 12'h0fc, 32'h00000000);
    chk(32'(rd_e), 32'h1);
  endtask : t_regs
  task t_mask();
    int i;
    wr(gic_pkg::GIC_ADDR_PRIM0, 8'h01);
    wr(gic_pkg::GIC_ADDR_GRP2, 8'h02);
    @(posedge sys_clk);
    timer_ovf_evt <= 4'h2;
    @(posedge sys_clk);
    timer_ovf_evt <= 4'h0;
    i = 0;
    while (wake !== 1'b1 && i < 5) begin
      @(posedge sys_clk);
      i++;
    end
    chk(32'(wake), 32'h1);
    no_take(4);
    rdc(gic_pkg::GIC_ADDR_GRP2, 8'h22);
    wr(gic_pkg::GIC_ADDR_PRIM2, 8'h22);
    take(12'h024);
    rdc(gic_pkg::GIC_ADDR_PRIM0, 8'h00);
    rdc(gic_pkg::GIC_ADDR_GRP2, 8'h22);
    @(posedge sys_clk);
    timer_ovf_evt <= 4'h1;
    @(posedge sys_clk);
    timer_ovf_evt <= 4'h0;
    rdc(gic_pkg::GIC_ADDR_GRP2, 8'h32);
    pop();
    wr(gic_pkg::GIC_ADDR_GRP2, 8'h00);
    wr(gic_pkg::GIC_ADDR_PRIM2, 8'h00);
  endtask : t_mask
  task t_global();
    wr(gic_pkg::GIC_ADDR_PRIM0, 8'h04);
    cmp_out <= 6'h02;
    no_take(6);
    rdc(gic_pkg::GIC_ADDR_PRIM0, 8'h24);
    slow <= 1'b1;
    wr(gic_pkg::GIC_ADDR_PRIM0, 8'h25);
    take(12'h008);
    rdc(gic_pkg::GIC_ADDR_PRIM0, 8'h04);
    pop();
    slow <= 1'b0;
  endtask : t_global
  task t_stack();
    stack_full <= 1'b1;
    wr(gic_pkg::GIC_ADDR_PRIM0, 8'h09);
    cmp_edge_event_signal <= 1'b0;
    no_take(8);
    stack_full <= 1'b0;
    take(12'h004);
    rdc(gic_pkg::GIC_ADDR_PRIM0, 8'h08);
    pop();
  endtask : t_stack
  task t_prio();
    wr(gic_pkg::GIC_ADDR_GRP0, 8'h02);
    wr(gic_pkg::GIC_ADDR_PRIM3, 8'h0a);
    twowire_evt <= 1'b1;
    cmp_out <= 6'h03;
    @(posedge sys_clk);
    twowire_evt <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wr(gic_pkg::GIC_ADDR_PRIM0, 8'h01);
    take(12'h01c);
    rdc(gic_pkg::GIC_ADDR_GRP0, 8'h22);
    wr(gic_pkg::GIC_ADDR_GRP0, 8'h02);
    pop();
    wr(gic_pkg::GIC_ADDR_PRIM0, 8'h01);
    take(12'h02c);
    pop();
  endtask : t_prio
  task end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    error_cnt = 0;
    n_checks = 0;
    {psel, penable, pwrite, stack_full, slow, twowire_evt, resetn} = '0;
    {pulse_autoshutdown_evt, pulse_retrigger_evt, pulse_timer_evt} = '0;
    {paddr, pwdata, cmp_out, timer_ovf_evt} = '0;
    cmp_edge_event_signal = 1'b1;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_mask();
    t_global();
    t_stack();
    t_prio();
    end_sim();
  end
endmodule : gic_top_tb
bind gic_top gic_monitor gic_monitor_i (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .next_pc, .stack_full, .irq_accept, .return_from_interrupt,
  .irq_take, .irq_vector, .push_addr, .pc_pop);
